// [hdl/mrb_pkg.sv]
// Package: constants of the management register bit block.
`default_nettype none
package mrb_pkg;
    // Clock and self-clearing function run time.
    localparam int unsigned CLK_HZ      = 25_000_000;
    localparam int unsigned SC_RUN_NS   = 1_000;
    localparam int unsigned SC_RUN_CYC  =
        (SC_RUN_NS * (CLK_HZ / 1_000_000) + 999) / 1_000;
    localparam int unsigned CNT_W       = 16;
    localparam logic [CNT_W-1:0] SC_LOAD = CNT_W'(SC_RUN_CYC - 1);
    localparam logic [CNT_W-1:0] CNT_ZERO = '0;

    // Register port geometry.
    localparam int unsigned ADDR_W = 4;
    localparam int unsigned DATA_W = 16;

    // Register addresses.
    localparam logic [ADDR_W-1:0] ADDR_CTRL     = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_STAT     = 4'h1;
    localparam logic [ADDR_W-1:0] ADDR_EXT      = 4'h2;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = 4'h3;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 4'h4;

    // Control register fields.
    localparam int unsigned CTRL_SRST_BIT = 15;
    localparam int unsigned CTRL_FUNC_BIT = 14;
    localparam int unsigned TEST_LSB      = 8;
    localparam int unsigned TEST_W        = 4;
    localparam int unsigned CFG_LSB       = 0;
    localparam int unsigned CFG_W         = 8;
    localparam logic [TEST_W-1:0] TEST_DEF = 4'ha;
    localparam logic [CFG_W-1:0]  CFG_DEF  = 8'h30;

    // Status register fields.
    localparam int unsigned STAT_EH_BIT = 15;
    localparam int unsigned STAT_EL_BIT = 14;
    localparam int unsigned MAX_LSB     = 11;
    localparam int unsigned MAX_W       = 3;
    localparam int unsigned STRAP_LSB   = 0;
    localparam int unsigned STRAP_W     = 5;

    // Extended register fields.
    localparam int unsigned EXT_OVR_BIT = 15;
    localparam int unsigned W0_LSB      = 8;
    localparam int unsigned W0_W        = 4;
    localparam int unsigned CW_LSB      = 0;
    localparam int unsigned CW_W        = 8;
    localparam logic [CW_W-1:0] CW_DEF  = 8'h00;
    localparam logic [W0_W-1:0] W0_DEF  = 4'h0;

    // Interrupt status and mask layout.
    localparam int unsigned IRQ_W        = 4;
    localparam int unsigned IRQ_EH_BIT   = 0;
    localparam int unsigned IRQ_EL_BIT   = 1;
    localparam int unsigned IRQ_MAX_BIT  = 2;
    localparam int unsigned IRQ_DONE_BIT = 3;
endpackage
`default_nettype wire

// [hdl/mrb_latch_if.sv]
// Interface: one latching event bit between owner and register logic.
`default_nettype none
interface mrb_latch_if;
    logic live;
    logic take;
    logic clear;
    logic value;
    logic hit;
    modport owner (input live, input take, input clear,
                   output value, output hit);
    modport user  (output live, output take, output clear,
                   input value, input hit);
endinterface
`default_nettype wire

// [hdl/mrb_event_latch.sv]
// Module: latching event bit, active level chosen by parameter.
`default_nettype none
module mrb_event_latch #(
    parameter logic ACTIVE = 1'h1
) (
    // Clock and control
    input  wire logic   mclk,
    input  wire logic   rst_n,
    input  wire logic   ce,
    // Latch signals
    mrb_latch_if.owner  lat
);
    typedef struct packed {
        logic value;
    } mrb_latch_state_type;

    localparam mrb_latch_state_type ST_RESET = '{value: ~ACTIVE};

    mrb_latch_state_type st;
    mrb_latch_state_type next_st;

    always_comb begin
        next_st = st;
        if (lat.clear) begin
            next_st.value = ~ACTIVE;
        end else if (lat.take) begin
            // Reload with the live level; an active level here is kept.
            next_st.value = lat.live; // R6 R8 R16
        end else if (lat.live == ACTIVE) begin
            next_st.value = ACTIVE; // R5 R7
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st <= ST_RESET;
        end else if (ce) begin
            st <= next_st;
        end
    end

    assign lat.value = st.value;
    assign lat.hit   = (lat.live == ACTIVE) && (st.value != ACTIVE)
                       && !lat.clear;
endmodule
`default_nettype wire

// [hdl/mrb_self_clear.sv]
// Module: self-clearing trigger bit with a fixed function run time.
`default_nettype none
module mrb_self_clear (
    // Clock and control
    input  wire logic mclk,
    input  wire logic rst_n,
    input  wire logic ce,
    // Trigger
    input  wire logic start,
    input  wire logic clear,
    output logic      busy
);
    typedef struct packed {
        logic                     busy;
        logic [mrb_pkg::CNT_W-1:0] cnt;
    } mrb_sc_state_type;

    localparam mrb_sc_state_type ST_RESET = '{busy: 1'h0, cnt: '0};

    mrb_sc_state_type st;
    mrb_sc_state_type next_st;

    always_comb begin
        next_st = st;
        if (clear) begin
            next_st = ST_RESET;
        end else if (!st.busy) begin
            if (start) begin
                next_st.busy = 1'h1; // R11
                next_st.cnt  = mrb_pkg::SC_LOAD;
            end
        end else if (st.cnt == mrb_pkg::CNT_ZERO) begin
            next_st.busy = 1'h0; // R12
        end else begin
            next_st.cnt = st.cnt - 16'h1;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st <= ST_RESET;
        end else if (ce) begin
            st <= next_st;
        end
    end

    assign busy = st.busy;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    a_sc_start_runs: assert property ( // R11
        ce && start && !clear && !st.busy |=> st.busy)
        else $error("trigger did not start its function");
    a_sc_self_clear: assert property ( // R12
        ce && !clear && st.busy && st.cnt == mrb_pkg::CNT_ZERO |=> !st.busy)
        else $error("trigger bit did not clear on completion");
    c_sc_done: cover property (st.busy ##1 !st.busy);
endmodule
`default_nettype wire

// [hdl/mrb_regs.sv]
// Module: management register bank with latching and trigger bit kinds.
//
// Function
// [R1] Reset loads defaults before accepting further writes.
// [R2] Defaults: none, zero, one, or pin level.
// [R3] Strapped bits capture pin level at reset.
// [R4] Software never changes reserved test bits; here every control register write loads them from wdata.
// [R5] Event-high bit sets and holds on event.
// [R6] Read reloads event-high bit with live level.
// [R7] Event-low bit clears and holds on event.
// [R8] Read reloads event-low bit with live level.
// [R9] Max group captures only larger state values.
// [R10] Max group holds until read, then reloads.
// [R11] Writing one to trigger starts function.
// [R12] Trigger bit self-clears once function completes.
// [R13] Writes to read-only bits are ignored.
// [R14] Override bit gates writes, clears on next write.
// [R15] Write-zero-only bits accept only zero writes.
// [R16] Event during post-read reload is kept.
`default_nettype none
module mrb_regs (
    // Clock, reset and clock enable
    input  wire logic                        mclk,
    input  wire logic                        resetn,
    input  wire logic                        ce,
    // Register port
    input  wire logic [mrb_pkg::ADDR_W-1:0]  addr,
    input  wire logic [mrb_pkg::DATA_W-1:0]  wdata,
    input  wire logic                        wr,
    input  wire logic                        rd,
    output logic      [mrb_pkg::DATA_W-1:0]  rdata,
    output logic                             irq,
    // Monitored signals and straps
    input  wire logic [mrb_pkg::STRAP_W-1:0] strap_pins,
    input  wire logic                        ev_high_live,
    input  wire logic                        ev_low_live_n,
    input  wire logic [mrb_pkg::MAX_W-1:0]   fsm_state,
    input  wire logic [mrb_pkg::W0_W-1:0]    w0_set,
    // Controlled functions
    output logic      [mrb_pkg::CFG_W-1:0]   cfg,
    output logic      [mrb_pkg::TEST_W-1:0]  test_mode,
    output logic      [mrb_pkg::CW_W-1:0]    cw_bits,
    output logic      [mrb_pkg::W0_W-1:0]    w0_bits,
    output logic                             func_active,
    output logic                             srst_active
);
    typedef struct packed {
        logic                        strapped;
        logic [mrb_pkg::STRAP_W-1:0] strap;
        logic [mrb_pkg::CFG_W-1:0]   cfg;
        logic [mrb_pkg::TEST_W-1:0]  test;
        logic                        ovr;
        logic [mrb_pkg::CW_W-1:0]    cw;
        logic [mrb_pkg::W0_W-1:0]    w0;
        logic [mrb_pkg::MAX_W-1:0]   maxv;
        logic                        func_prev;
        logic [mrb_pkg::IRQ_W-1:0]   irq_stat;
        logic [mrb_pkg::IRQ_W-1:0]   irq_mask;
        logic                        irq;
        logic [mrb_pkg::DATA_W-1:0]  rdata;
    } mrb_state_type;

    localparam mrb_state_type ST_RESET = '{
        strapped:  1'h0,
        strap:     '0,
        cfg:       mrb_pkg::CFG_DEF,
        test:      mrb_pkg::TEST_DEF,
        ovr:       1'h0,
        cw:        mrb_pkg::CW_DEF,
        w0:        mrb_pkg::W0_DEF,
        maxv:      '0,
        func_prev: 1'h0,
        irq_stat:  '0,
        irq_mask:  '0,
        irq:       1'h0,
        rdata:     '0
    };

    function automatic logic is_reg(
        input logic [mrb_pkg::ADDR_W-1:0] a,
        input logic [mrb_pkg::ADDR_W-1:0] target
    );
        return a == target;
    endfunction

    logic [1:0]    rst_pipe;
    logic          rst_n;
    mrb_state_type st;
    mrb_state_type next_st;
    logic          accept;
    logic          stat_take;
    logic          srst_busy;
    logic          func_busy;
    logic          srst_start;
    logic          func_start;
    logic [mrb_pkg::IRQ_W-1:0]  events;
    logic [mrb_pkg::DATA_W-1:0] read_word;

    mrb_latch_if eh_if ();
    mrb_latch_if el_if ();

    // Reset is released through two flip-flops.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rst_pipe <= 2'h0;
        end else begin
            rst_pipe <= {rst_pipe[0], 1'h1};
        end
    end
    assign rst_n = rst_pipe[1];

    // Writes wait until defaults and straps are in place.
    assign accept     = st.strapped && !srst_busy; // R1
    assign stat_take  = rd && accept && is_reg(addr, mrb_pkg::ADDR_STAT);
    assign srst_start = wr && accept && is_reg(addr, mrb_pkg::ADDR_CTRL)
                        && wdata[mrb_pkg::CTRL_SRST_BIT];
    assign func_start = wr && accept && is_reg(addr, mrb_pkg::ADDR_CTRL)
                        && wdata[mrb_pkg::CTRL_FUNC_BIT];

    assign eh_if.live  = ev_high_live;
    assign eh_if.take  = stat_take;
    assign eh_if.clear = srst_busy;
    assign el_if.live  = ev_low_live_n;
    assign el_if.take  = stat_take;
    assign el_if.clear = srst_busy;

    mrb_event_latch #(.ACTIVE(1'h1)) u_eh (
        .mclk  (mclk),
        .rst_n (rst_n),
        .ce    (ce),
        .lat   (eh_if.owner)
    );

    mrb_event_latch #(.ACTIVE(1'h0)) u_el (
        .mclk  (mclk),
        .rst_n (rst_n),
        .ce    (ce),
        .lat   (el_if.owner)
    );

    // Software reset: while it runs every register except the read data register and its own busy bit is held at default.
    mrb_self_clear u_srst (
        .mclk  (mclk),
        .rst_n (rst_n),
        .ce    (ce),
        .start (srst_start),
        .clear (1'h0),
        .busy  (srst_busy)
    );

    mrb_self_clear u_func (
        .mclk  (mclk),
        .rst_n (rst_n),
        .ce    (ce),
        .start (func_start),
        .clear (srst_busy),
        .busy  (func_busy)
    );

    always_comb begin
        events = '0;
        events[mrb_pkg::IRQ_EH_BIT]   = eh_if.hit;
        events[mrb_pkg::IRQ_EL_BIT]   = el_if.hit;
        events[mrb_pkg::IRQ_MAX_BIT]  = !srst_busy && fsm_state > st.maxv;
        events[mrb_pkg::IRQ_DONE_BIT] = st.func_prev && !func_busy;
    end

    always_comb begin
        read_word = '0;
        case (addr)
            mrb_pkg::ADDR_CTRL: begin
                read_word[mrb_pkg::CTRL_SRST_BIT] = srst_busy; // R12
                read_word[mrb_pkg::CTRL_FUNC_BIT] = func_busy; // R12
                read_word[mrb_pkg::TEST_LSB +: mrb_pkg::TEST_W] = st.test;
                read_word[mrb_pkg::CFG_LSB +: mrb_pkg::CFG_W]   = st.cfg;
            end
            mrb_pkg::ADDR_STAT: begin
                read_word[mrb_pkg::STAT_EH_BIT] = eh_if.value;
                read_word[mrb_pkg::STAT_EL_BIT] = el_if.value;
                read_word[mrb_pkg::MAX_LSB +: mrb_pkg::MAX_W] = st.maxv;
                read_word[mrb_pkg::STRAP_LSB +: mrb_pkg::STRAP_W] = st.strap;
            end
            mrb_pkg::ADDR_EXT: begin
                read_word[mrb_pkg::EXT_OVR_BIT] = st.ovr;
                read_word[mrb_pkg::W0_LSB +: mrb_pkg::W0_W] = st.w0;
                read_word[mrb_pkg::CW_LSB +: mrb_pkg::CW_W] = st.cw;
            end
            mrb_pkg::ADDR_IRQ_STAT: begin
                read_word[mrb_pkg::IRQ_W-1:0] = st.irq_stat;
            end
            mrb_pkg::ADDR_IRQ_MASK: begin
                read_word[mrb_pkg::IRQ_W-1:0] = st.irq_mask;
            end
            default: begin
                read_word = '0;
            end
        endcase
    end

    always_comb begin
        next_st = st;
        if (srst_busy) begin
            next_st = ST_RESET; // R1 R2
        end else if (!st.strapped) begin
            next_st.strap    = strap_pins; // R3
            next_st.strapped = 1'h1;
        end else if (wr) begin
            // A write to the status register changes only the override bit. R13
            next_st.ovr = 1'h0; // R14
            if (is_reg(addr, mrb_pkg::ADDR_CTRL)) begin
                next_st.cfg  = wdata[mrb_pkg::CFG_LSB +: mrb_pkg::CFG_W];
                next_st.test = wdata[mrb_pkg::TEST_LSB +: mrb_pkg::TEST_W];
            end
            if (is_reg(addr, mrb_pkg::ADDR_EXT)) begin
                next_st.ovr = !st.ovr && wdata[mrb_pkg::EXT_OVR_BIT];
                if (st.ovr) begin
                    next_st.cw = wdata[mrb_pkg::CW_LSB +: mrb_pkg::CW_W]; // R14
                end
                next_st.w0 = st.w0 & wdata[mrb_pkg::W0_LSB +: mrb_pkg::W0_W];
            end
            if (is_reg(addr, mrb_pkg::ADDR_IRQ_MASK)) begin
                next_st.irq_mask = wdata[mrb_pkg::IRQ_W-1:0];
            end
        end
        if (!srst_busy) begin
            // Hardware set wins over a zero write. R15
            next_st.w0 = next_st.w0 | w0_set;
            if (stat_take) begin
                next_st.maxv = fsm_state; // R10
            end else if (fsm_state > st.maxv) begin
                next_st.maxv = fsm_state; // R9
            end
            next_st.func_prev = func_busy;
            next_st.irq_stat  = st.irq_stat | events;
            if (wr && accept && is_reg(addr, mrb_pkg::ADDR_IRQ_STAT)) begin
                next_st.irq_stat = (st.irq_stat & ~wdata[mrb_pkg::IRQ_W-1:0])
                                   | events;
            end
        end
        next_st.irq   = |(next_st.irq_stat & next_st.irq_mask);
        next_st.rdata = rd ? read_word : '0;
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st <= ST_RESET;
        end else if (ce) begin
            st <= next_st;
        end
    end

    assign rdata       = st.rdata;
    assign irq         = st.irq;
    assign cfg         = st.cfg;
    assign test_mode   = st.test;
    assign cw_bits     = st.cw;
    assign w0_bits     = st.w0;
    assign func_active = func_busy;
    assign srst_active = srst_busy;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    a_soft_reset_defaults: assert property ( // R1
        ce && srst_busy |=> st.cfg == mrb_pkg::CFG_DEF
            && st.cw == mrb_pkg::CW_DEF && !st.strapped)
        else $error("defaults not loaded during software reset");
    a_strap_capture: assert property ( // R3
        ce && !srst_busy && !st.strapped
            |=> st.strapped && st.strap == $past(strap_pins))
        else $error("strap level not captured");
    a_eh_holds_event: assert property ( // R5
        ce && ev_high_live && !srst_busy |=> eh_if.value)
        else $error("event-high bit did not latch");
    a_eh_read_reload: assert property ( // R6
        ce && stat_take && !srst_busy |=> eh_if.value == $past(ev_high_live))
        else $error("event-high bit not reloaded after read");
    a_el_holds_event: assert property ( // R7
        ce && !ev_low_live_n && !srst_busy |=> !el_if.value)
        else $error("event-low bit did not latch");
    a_el_read_reload: assert property ( // R8
        ce && stat_take && !srst_busy
            |=> el_if.value == $past(ev_low_live_n))
        else $error("event-low bit not reloaded after read");
    a_max_no_lower: assert property ( // R9
        ce && !srst_busy && !stat_take && fsm_state <= st.maxv
            |=> $stable(st.maxv))
        else $error("max group took a smaller value");
    a_max_read_reload: assert property ( // R10
        ce && stat_take && !srst_busy |=> st.maxv == $past(fsm_state))
        else $error("max group not reloaded after read");
    a_status_ro: assert property ( // R13
        ce && wr && is_reg(addr, mrb_pkg::ADDR_STAT) && accept
            |=> $stable(st.strap) && $stable(st.cfg))
        else $error("write to read-only register changed state");
    a_cw_gated: assert property ( // R14
        ce && wr && !st.ovr && !srst_busy |=> $stable(st.cw))
        else $error("override-gated bits changed without override");
    a_ovr_clears: assert property ( // R14
        ce && wr && st.ovr && accept |=> !st.ovr)
        else $error("override bit did not clear on write");
    a_w0_no_set: assert property ( // R15
        ce && !srst_busy && w0_set == '0 ##1 1'h1
            |-> (st.w0 & ~$past(st.w0)) == '0)
        else $error("write-zero-only bit was set by a write");

    c_eh_history_then_live: cover property (
        eh_if.value && stat_take ##1 !eh_if.value);
    c_soft_reset_done: cover property (srst_busy ##1 !srst_busy);
    c_cw_override_write: cover property (
        st.ovr && wr && is_reg(addr, mrb_pkg::ADDR_EXT));
    c_irq_raised: cover property (!st.irq ##1 st.irq);
endmodule
`default_nettype wire

// [testbench/mrb_sta_model.sv]
// Station management model that drives the register port through tasks.
`default_nettype none
module mrb_sta_model (
    // Clock
    input  wire logic                       mclk,
    // Register port
    output logic      [mrb_pkg::ADDR_W-1:0] addr,
    output logic      [mrb_pkg::DATA_W-1:0] wdata,
    output logic                            wr,
    output logic                            rd,
    input  wire logic [mrb_pkg::DATA_W-1:0] rdata
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        addr  = '0;
        wdata = '0;
        wr    = 1'b0;
        rd    = 1'b0;
    end

    // Released write data is inverted so a stale value is never mistaken.
    task automatic write_reg(input logic [mrb_pkg::ADDR_W-1:0] a,
                             input logic [mrb_pkg::DATA_W-1:0] v);
        @(posedge mclk);
        addr  <= a;
        wdata <= v;
        wr    <= 1'b1;
        @(posedge mclk);
        wr    <= 1'b0;
        wdata <= ~v;
    endtask

    // Read data stand only in the cycle after the strobe.
    task automatic read_reg(input  logic [mrb_pkg::ADDR_W-1:0] a,
                            output logic [mrb_pkg::DATA_W-1:0] v);
        @(posedge mclk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge mclk);
        rd   <= 1'b0;
        #1;
        v = rdata;
    endtask
endmodule
`default_nettype wire

// [testbench/mgmt_register_bit_semantics_tb.sv]
// Testbench for the management register bank and its bit kinds.
`default_nettype none
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin \
    error_cnt++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (e)); end end
module mgmt_register_bit_semantics_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic                         mclk          = 1'b0;
    logic                         resetn        = 1'b0;
    logic [mrb_pkg::ADDR_W-1:0]   addr;
    logic [mrb_pkg::DATA_W-1:0]   wdata;
    logic                         wr;
    logic                         rd;
    logic [mrb_pkg::DATA_W-1:0]   rdata;
    logic                         irq;
    logic [mrb_pkg::STRAP_W-1:0]  strap_pins    = 5'h15;
    logic                         ev_high_live  = 1'b0;
    logic                         ev_low_live_n = 1'b1;
    logic [mrb_pkg::MAX_W-1:0]    fsm_state     = 3'h0;
    logic [mrb_pkg::W0_W-1:0]     w0_set        = 4'h0;
    logic [mrb_pkg::CFG_W-1:0]    cfg;
    logic [mrb_pkg::TEST_W-1:0]   test_mode;
    logic [mrb_pkg::CW_W-1:0]     cw_bits;
    logic [mrb_pkg::W0_W-1:0]     w0_bits;
    logic                         func_active;
    logic                         srst_active;
    logic [mrb_pkg::DATA_W-1:0]   d;
    int                           error_cnt     = 0;
    int                           num_checks    = 0;
    int                           cnt;

    always #20 mclk = ~mclk;

    mrb_sta_model i_mrb_sta_model (
        .mclk (mclk), .addr (addr), .wdata (wdata),
        .wr (wr), .rd (rd), .rdata (rdata)
    );

    mrb_regs i_mrb_regs (
        .mclk (mclk), .resetn (resetn), .ce (1'b1),
        .addr (addr), .wdata (wdata), .wr (wr), .rd (rd),
        .rdata (rdata), .irq (irq), .strap_pins (strap_pins),
        .ev_high_live (ev_high_live), .ev_low_live_n (ev_low_live_n),
        .fsm_state (fsm_state), .w0_set (w0_set), .cfg (cfg),
        .test_mode (test_mode), .cw_bits (cw_bits), .w0_bits (w0_bits),
        .func_active (func_active), .srst_active (srst_active)
    );

    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask

    task automatic wreg(input logic [mrb_pkg::ADDR_W-1:0] a,
                        input logic [mrb_pkg::DATA_W-1:0] v);
        i_mrb_sta_model.write_reg(a, v);
    endtask

    task automatic rreg(input logic [mrb_pkg::ADDR_W-1:0] a);
        i_mrb_sta_model.read_reg(a, d);
    endtask

    // Control words always carry the reserved test field at its default.
    function automatic logic [15:0] keep(input logic [1:0] trig,
                                         input logic [7:0] c);
        return {trig, 2'b00, mrb_pkg::TEST_DEF, c};
    endfunction

    task automatic wrap_up;
        $display("checks %0d, mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial begin
        tick(3000);
        error_cnt++;
        $display("[FAIL] t=%0t watchdog expired", $time);
        wrap_up();
    end

    initial begin
        tick(20);
        resetn <= 1'b1;
        tick(5);
        rreg(mrb_pkg::ADDR_CTRL);
        `CHK(d & 16'hcfff, 16'h0a30)
        strap_pins <= 5'h0c;
        rreg(mrb_pkg::ADDR_STAT);
        `CHK(d[15:11], 5'b01000)
        `CHK(d[4:0], 5'h15)
        rreg(mrb_pkg::ADDR_EXT);
        `CHK(d, 16'h0000)
        `CHK(irq, 1'b0)
        wreg(mrb_pkg::ADDR_STAT, 16'h3fff);
        rreg(mrb_pkg::ADDR_STAT);
        `CHK({d[15:11], d[4:0]}, 10'h115)
        wreg(4'h7, 16'hffff);
        rreg(4'h7);
        `CHK(d, 16'h0000)
        tick(1);
        #1;
        `CHK(rdata, 16'h0000)
        $display("test defaults done");

        ev_high_live <= 1'b1;
        tick(1);
        ev_high_live <= 1'b0;
        tick(3);
        rreg(mrb_pkg::ADDR_STAT);
        `CHK(d[15], 1'b1)
        rreg(mrb_pkg::ADDR_STAT);
        `CHK(d[15], 1'b0)
        fork
            rreg(mrb_pkg::ADDR_STAT);
            begin
                tick(1);
                ev_high_live <= 1'b1;
                tick(1);
                ev_high_live <= 1'b0;
            end
        join
        rreg(mrb_pkg::ADDR_STAT);
        `CHK(d[15], 1'b1)
        rreg(mrb_pkg::ADDR_STAT);
        `CHK(d[15], 1'b0)
        ev_low_live_n <= 1'b0;
        tick(1);
        ev_low_live_n <= 1'b1;
        tick(3);
        rreg(mrb_pkg::ADDR_STAT);
        `CHK(d[14], 1'b0)
        rreg(mrb_pkg::ADDR_STAT);
        `CHK(d[14], 1'b1)
        $display("test event latches done");

        fsm_state <= 3'h3;
        tick(2);
        fsm_state <= 3'h2;
        tick(2);
        rreg(mrb_pkg::ADDR_STAT);
        `CHK(d[13:11], 3'h3)
        rreg(mrb_pkg::ADDR_STAT);
        `CHK(d[13:11], 3'h2)
        fsm_state <= 3'h4;
        tick(2);
        fsm_state <= 3'h1;
        tick(2);
        rreg(mrb_pkg::ADDR_STAT);
        `CHK(d[13:11], 3'h4)
        rreg(mrb_pkg::ADDR_STAT);
        `CHK(d[13:11], 3'h1)
        fsm_state <= 3'h0;
        $display("test maximum group done");

        wreg(mrb_pkg::ADDR_IRQ_STAT, 16'h000f);
        wreg(mrb_pkg::ADDR_IRQ_MASK, 16'h0008);
        #1;
        `CHK(irq, 1'b0)
        wreg(mrb_pkg::ADDR_CTRL, keep(2'b01, 8'h30));
        cnt = 0;
        repeat (40) begin
            #1;
            if (func_active === 1'b1)
                cnt++;
            @(posedge mclk);
        end
        `CHK(cnt, mrb_pkg::SC_RUN_CYC)
        rreg(mrb_pkg::ADDR_CTRL);
        `CHK(d & 16'hcfff, 16'h0a30)
        `CHK(irq, 1'b1)
        wreg(mrb_pkg::ADDR_IRQ_MASK, 16'h0000);
        #1;
        `CHK(irq, 1'b0)
        wreg(mrb_pkg::ADDR_IRQ_MASK, 16'h0008);
        #1;
        `CHK(irq, 1'b1)
        wreg(mrb_pkg::ADDR_IRQ_STAT, 16'h0008);
        tick(1);
        #1;
        `CHK(irq, 1'b0)
        $display("test self clearing done");

        wreg(mrb_pkg::ADDR_EXT, 16'h005a);
        rreg(mrb_pkg::ADDR_EXT);
        `CHK(d, 16'h0000)
        wreg(mrb_pkg::ADDR_EXT, 16'h8000);
        rreg(mrb_pkg::ADDR_EXT);
        `CHK(d, 16'h8000)
        wreg(mrb_pkg::ADDR_EXT, 16'h005a);
        rreg(mrb_pkg::ADDR_EXT);
        `CHK(d, 16'h005a)
        wreg(mrb_pkg::ADDR_EXT, 16'h8000);
        wreg(mrb_pkg::ADDR_CTRL, keep(2'b00, 8'h55));
        wreg(mrb_pkg::ADDR_EXT, 16'h00a5);
        rreg(mrb_pkg::ADDR_EXT);
        `CHK(d, 16'h005a)
        `CHK(cfg, 8'h55)
        w0_set <= 4'hf;
        tick(1);
        w0_set <= 4'h0;
        wreg(mrb_pkg::ADDR_EXT, 16'h0f00);
        rreg(mrb_pkg::ADDR_EXT);
        `CHK(d, 16'h0f5a)
        wreg(mrb_pkg::ADDR_EXT, 16'h0000);
        rreg(mrb_pkg::ADDR_EXT);
        `CHK(d, 16'h005a)
        `CHK(w0_bits, 4'h0)
        $display("test gated writes done");

        wreg(mrb_pkg::ADDR_CTRL, keep(2'b10, 8'h55));
        rreg(mrb_pkg::ADDR_CTRL);
        `CHK(d[15], 1'b1)
        `CHK(srst_active, 1'b1)
        cnt = 0;
        while (d[15] === 1'b1 && cnt < 40) begin
            rreg(mrb_pkg::ADDR_CTRL);
            cnt++;
        end
        tick(3);
        #1;
        `CHK(cfg, mrb_pkg::CFG_DEF)
        `CHK(cw_bits, 8'h00)
        `CHK(srst_active, 1'b0)
        `CHK(test_mode, mrb_pkg::TEST_DEF)
        rreg(mrb_pkg::ADDR_STAT);
        `CHK(d[4:0], 5'h0c)
        rreg(mrb_pkg::ADDR_IRQ_MASK);
        `CHK(d, 16'h0000)
        $display("test soft reset done");
        wrap_up();
    end
endmodule
`default_nettype wire
